// *** pkg/dmd_map.svh ***
// Register offsets, field positions and reset values of the descriptor decoder
`ifndef DMD_MAP_SVH
`define DMD_MAP_SVH

// ----
// Register byte offsets
// ----
`define DMD_OFS_DESC 5'h00
`define DMD_OFS_KIND 5'h04
`define DMD_OFS_GO 5'h08
`define DMD_OFS_STATUS 5'h0C
`define DMD_OFS_RES0 5'h10
`define DMD_OFS_RES1 5'h14
`define DMD_OFS_SCRATCH 5'h18
`define DMD_OFS_QUERY 5'h1C

// ----
// Descriptor field positions
// ----
`define DMD_F_INDEX 7:0
`define DMD_F_CHANNEL_DISABLE_MASK 11:8
`define DMD_F_LANE_A 8
`define DMD_F_ELEM 11:10
`define DMD_F_BLK 10:8
`define DMD_F_WIDE_S 13:12
`define DMD_F_LANE_B 13:12
`define DMD_F_SLOT 13:12
`define DMD_F_SCRATCH 11:0
`define DMD_F_HDR 19
`define DMD_F_PACKED 30

// ----
// Surface index codes and field limits
// ----
`define DMD_IDX_BTI_MAX 8'hEF
`define DMD_IDX_SSO 8'hFC
`define DMD_IDX_NC 8'hFD
`define DMD_IDX_SLM 8'hFE
`define DMD_IDX_COH 8'hFF
`define DMD_MASK_NONE 4'hF
`define DMD_UW_RGBA 4'h0
`define DMD_UW_RGB 4'h8
`define DMD_UW_RG 4'hC
`define DMD_UW_R 4'hE
`define DMD_LANE_B16 2'h1
`define DMD_LANE_B8 2'h2
`define DMD_SLOT_MAX 2'h2
`define DMD_OW_MAX 3'h4
`define DMD_WIDE_BLOCK_COUNT_LONG_ADDR_ONE 3'h1
`define DMD_WIDE_BLOCK_COUNT_LONG_ADDR_TWO 3'h2
`define DMD_SCRATCH_SHIFT 5

// ----
// Reset values
// ----
`define DMD_RST_DESC 32'h0000_0000
`define DMD_RST_KIND 8'h00

`endif

// *** pkg/dmd_pkg.sv ***
// Types shared by the descriptor decoder modules
`default_nettype none
package dmd_pkg;
    // Message kind, written by software into the kind register
    typedef enum logic [2:0] {
        DMD_UNTYPED_RD, DMD_UNTYPED_WR, DMD_TYPED_RD, DMD_TYPED_WR,
        DMD_GATHER_RD, DMD_BLOCK_HW, DMD_BLOCK_OW, DMD_SCRATCH
    } dmd_kind_t;
    // Address model of the message
    typedef enum logic [1:0] {
        DMD_AM_A64, DMD_AM_BTS, DMD_AM_SLM_A32, DMD_AM_BAD
    } dmd_model_t;
    // Resolved surface class
    typedef enum logic [2:0] {
        DMD_SC_NONE, DMD_SC_BTI, DMD_SC_SSO, DMD_SC_NC, DMD_SC_COH, DMD_SC_SLM
    } dmd_surf_t;
endpackage
`default_nettype wire

// *** pkg/dmd_surf_if.sv ***
// Carrier between the decoder top and its surface index resolver
`timescale 1ns/10ps
`default_nettype none
interface dmd_surf_if;
    import dmd_pkg::*;
    dmd_model_t model;
    logic [7:0] index;
    dmd_surf_t cls;
    logic ok;
    modport top (output model, output index, input cls, input ok);
    modport res (input model, input index, output cls, output ok);
endinterface
`default_nettype wire

// *** hw/dmd_surf_res.sv ***
// Surface index resolver for the descriptor decoder
`timescale 1ns/10ps
`default_nettype none
`include "dmd_map.svh"
module dmd_surf_res
    import dmd_pkg::*;
(
    // Carrier
    dmd_surf_if.res s
);
    wire logic is_bti;
    wire logic is_sso;
    wire logic is_nc;
    wire logic is_slm;
    wire logic is_coh;
    dmd_surf_t cls_a64;
    dmd_surf_t cls_bts;
    dmd_surf_t cls_slm;

    assign is_bti = (s.index <= `DMD_IDX_BTI_MAX);
    assign is_sso = (s.index == `DMD_IDX_SSO);
    assign is_nc = (s.index == `DMD_IDX_NC);
    assign is_slm = (s.index == `DMD_IDX_SLM);
    assign is_coh = (s.index == `DMD_IDX_COH);

    // Long addresses only reach stateless space
    assign cls_a64 = is_coh ? DMD_SC_COH : (is_nc ? DMD_SC_NC : DMD_SC_NONE);
    // Bound-only model has tables and state offset, nothing stateless
    assign cls_bts = is_bti ? DMD_SC_BTI : (is_sso ? DMD_SC_SSO : DMD_SC_NONE);
    assign cls_slm = is_bti ? DMD_SC_BTI :
                     is_sso ? DMD_SC_SSO :
                     is_nc ? DMD_SC_NC :
                     is_slm ? DMD_SC_SLM :
                     is_coh ? DMD_SC_COH : DMD_SC_NONE;

    assign s.cls = (s.model == DMD_AM_A64) ? cls_a64 :
                   (s.model == DMD_AM_BTS) ? cls_bts :
                   (s.model == DMD_AM_SLM_A32) ? cls_slm : DMD_SC_NONE;
    assign s.ok = (s.cls != DMD_SC_NONE);
endmodule
`default_nettype wire

// *** hw/dmd_decoder.sv ***
// Data-port message descriptor decoder with Avalon-MM register access
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "dmd_map.svh"
module dmd_decoder
    import dmd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Access request toward the data port
    output logic access_issue_o,
    output logic [31:0] access_desc_o,
    output logic [2:0] access_kind_o,
    output logic access_refused_o
);
    // ----
    // Functions
    // ----
    function automatic logic [2:0] kept_count(input logic [3:0] m);
        kept_count = 3'(!m[0]) + 3'(!m[1]) + 3'(!m[2]) + 3'(!m[3]);
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        be_merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                be_merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // ----
    // Registers
    // ----
    logic [31:0] desc_reg;
    logic [7:0] kind_reg;
    logic refused_reg;
    logic [4:0] query_reg;
    logic [31:0] res0_reg;
    logic [31:0] res1_reg;
    logic [16:0] scratch_reg;
    logic invalid_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic issue_reg;
    logic refuse_pulse_reg;
    logic [31:0] adesc_reg;
    logic [2:0] akind_reg;

    // ----
    // Bus decode
    // ----
    wire logic acc_edge;
    wire logic wr_take;
    wire logic wr_desc;
    wire logic wr_kind;
    wire logic wr_go;
    wire logic wr_status;
    wire logic wr_query;
    wire logic go_cmd;

    // The request is taken at the edge where waitrequest is seen low
    assign acc_edge = !wait_reg && (avs_read_i || avs_write_i);
    assign wr_take = acc_edge && avs_write_i;
    assign wr_desc = wr_take && (avs_address_i == `DMD_OFS_DESC);
    assign wr_kind = wr_take && (avs_address_i == `DMD_OFS_KIND) && avs_byteenable_i[0];
    assign wr_go = wr_take && (avs_address_i == `DMD_OFS_GO) && avs_byteenable_i[0];
    assign wr_status = wr_take && (avs_address_i == `DMD_OFS_STATUS) && avs_byteenable_i[0];
    assign wr_query = wr_take && (avs_address_i == `DMD_OFS_QUERY) && avs_byteenable_i[0];
    assign go_cmd = wr_go && avs_writedata_i[0];

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    dmd_kind_t kind;
    dmd_model_t model;
    wire logic [3:0] channel_disable_mask;
    wire logic [1:0] elem_code;
    wire logic [2:0] blk_code;
    wire logic [1:0] wide_s_code;
    wire logic [1:0] lane_b_code;
    wire logic [1:0] slot_code;
    wire logic is_surface;
    wire logic is_typed;
    wire logic is_untyped_wr;
    wire logic uses_index;

    assign kind = dmd_kind_t'(kind_reg[2:0]);
    assign model = dmd_model_t'(kind_reg[5:4]);
    // Every field slice is taken out whatever the current kind is
    assign channel_disable_mask = desc_reg[`DMD_F_CHANNEL_DISABLE_MASK];
    assign elem_code = desc_reg[`DMD_F_ELEM];
    assign blk_code = desc_reg[`DMD_F_BLK];
    assign wide_s_code = desc_reg[`DMD_F_WIDE_S];
    assign lane_b_code = desc_reg[`DMD_F_LANE_B];
    assign slot_code = desc_reg[`DMD_F_SLOT];
    assign is_surface = (kind == DMD_UNTYPED_RD) || (kind == DMD_UNTYPED_WR) ||
                        (kind == DMD_TYPED_RD) || (kind == DMD_TYPED_WR);
    assign is_typed = (kind == DMD_TYPED_RD) || (kind == DMD_TYPED_WR);
    assign is_untyped_wr = (kind == DMD_UNTYPED_WR);
    // Scratch carries an offset where other kinds carry an index
    assign uses_index = (kind != DMD_SCRATCH);

    // ----------------------------------------
    // Surface index resolution
    // ----------------------------------------
    dmd_surf_if surf_c ();

    assign surf_c.model = model;
    assign surf_c.index = desc_reg[`DMD_F_INDEX];

    dmd_surf_res u_surf_res (
        .s(surf_c.res)
    );

    // ----------------------------------------
    // Channel mask
    // ----------------------------------------
    wire logic [3:0] chan_keep;
    wire logic [2:0] chan_cnt;
    wire logic mask_ok;
    wire logic uw_mask_ok;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_chan
            // Bit 0 is red, then green, blue, alpha; a set bit drops the channel
            assign chan_keep[gi] = !channel_disable_mask[gi];
        end
    endgenerate
    assign chan_cnt = kept_count(channel_disable_mask);
    assign mask_ok = (channel_disable_mask != `DMD_MASK_NONE);
    assign uw_mask_ok = (channel_disable_mask == `DMD_UW_RGBA) || (channel_disable_mask == `DMD_UW_RGB) ||
                        (channel_disable_mask == `DMD_UW_RG) || (channel_disable_mask == `DMD_UW_R);

    // ----------------------------------------
    // Elements, lanes and layout
    // ----------------------------------------
    wire logic [3:0] elem_cnt;
    wire logic lanes16;
    wire logic lane_ok;
    wire logic [4:0] lanes;
    wire logic [1:0] regs_per_elem;
    wire logic [2:0] group_cnt;
    wire logic [6:0] return_regs;
    wire logic slot_ok;

    // Gathers carry 1, 2, 4 or 8 elements per lane; surfaces scale by kept channels
    assign elem_cnt = (kind == DMD_GATHER_RD) ? 4'(4'h1 << elem_code) : 4'h1;
    // Typed kinds put the slot group in the lane width bits
    assign lanes16 = (kind == DMD_GATHER_RD) ? desc_reg[`DMD_F_LANE_A] :
                     (!is_typed && (lane_b_code == `DMD_LANE_B16));
    assign lane_ok = !is_surface || is_typed || (lane_b_code == `DMD_LANE_B16) ||
                     (lane_b_code == `DMD_LANE_B8);
    assign lanes = lanes16 ? 5'h10 : 5'h08;
    assign regs_per_elem = lanes16 ? 2'h2 : 2'h1;
    assign group_cnt = is_surface ? chan_cnt : 3'h1;
    assign return_regs = 7'(elem_cnt * group_cnt * regs_per_elem);
    assign slot_ok = !is_typed || (slot_code <= `DMD_SLOT_MAX);

    // Register of element e, channel c: all channels of element 0 come first
    wire logic [2:0] q_elem;
    wire logic [1:0] q_chan;
    wire logic [6:0] q_index;

    assign q_elem = query_reg[2:0];
    assign q_chan = query_reg[4:3];
    assign q_index = 7'((7'(q_elem) * 7'(group_cnt) + 7'(q_chan)) * 7'(regs_per_elem));

    // ----------------------------------------
    // Block counts
    // ----------------------------------------
    logic [3:0] blk_cnt;
    logic [2:0] blk_regs;
    logic blk_high;
    logic blk_ok;

    always_comb begin
        blk_cnt = 4'h0;
        blk_regs = 3'h0;
        blk_high = 1'b0;
        blk_ok = 1'b1;
        case (kind)
            DMD_BLOCK_HW: begin
                if (model == DMD_AM_A64) begin
                    blk_ok = (blk_code == `DMD_WIDE_BLOCK_COUNT_LONG_ADDR_ONE) || (blk_code == `DMD_WIDE_BLOCK_COUNT_LONG_ADDR_TWO);
                    blk_cnt = {1'b0, blk_code};
                    blk_regs = blk_code;
                end else begin
                    blk_cnt = 4'(4'h1 << blk_code[1:0]);
                    blk_regs = blk_cnt[2:0] | {blk_cnt[3], 2'b00};
                    blk_ok = !blk_code[2];
                end
            end
            DMD_BLOCK_OW: begin
                blk_ok = (blk_code <= `DMD_OW_MAX);
                case (blk_code)
                    3'h0: begin
                        blk_cnt = 4'h1;
                    end
                    3'h1: begin
                        blk_cnt = 4'h1;
                        blk_high = 1'b1;
                    end
                    3'h2: begin
                        blk_cnt = 4'h2;
                        blk_regs = 3'h1;
                    end
                    3'h3: begin
                        blk_cnt = 4'h4;
                        blk_regs = 3'h2;
                    end
                    3'h4: begin
                        blk_cnt = 4'h8;
                        blk_regs = 3'h4;
                    end
                    default: begin
                        blk_cnt = 4'h0;
                    end
                endcase
            end
            DMD_SCRATCH: begin
                blk_cnt = 4'(4'h1 << wide_s_code);
                blk_regs = 3'(blk_cnt);
            end
            default: begin
                blk_cnt = 4'h0;
            end
        endcase
    end

    // ----
    // Validity and results
    // ----
    wire logic fields_ok;
    wire logic [31:0] res0_next;
    wire logic [31:0] res1_next;
    wire logic [16:0] scratch_next;

    assign fields_ok = (!uses_index || surf_c.ok) && lane_ok && slot_ok && blk_ok &&
                       (!is_surface || mask_ok) && (!is_untyped_wr || uw_mask_ok) &&
                       (model != DMD_AM_BAD);
    assign res0_next = {2'b00, desc_reg[`DMD_F_PACKED], desc_reg[`DMD_F_HDR], elem_cnt,
                        1'b0, chan_cnt, chan_keep, desc_reg[`DMD_F_INDEX], 5'h00, surf_c.cls};
    assign res1_next = {9'h000, return_regs, regs_per_elem[1], lanes, slot_code,
                        blk_high, blk_regs, blk_cnt};
    assign scratch_next = {desc_reg[`DMD_F_SCRATCH], 5'h00};

    // ----
    // Read mux
    // ----
    logic [31:0] rd_mux;

    always_comb begin
        case (avs_address_i)
            `DMD_OFS_DESC: rd_mux = desc_reg;
            `DMD_OFS_KIND: rd_mux = {24'h000000, kind_reg};
            `DMD_OFS_STATUS: rd_mux = {30'h0000_0000, refused_reg, invalid_reg};
            `DMD_OFS_RES0: rd_mux = res0_reg;
            `DMD_OFS_RES1: rd_mux = res1_reg;
            `DMD_OFS_SCRATCH: rd_mux = {15'h0000, scratch_reg};
            `DMD_OFS_QUERY: rd_mux = {16'h0000, 1'b0, q_index, 3'h0, query_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ----
    // Bus handshake
    // ----
    // One wait cycle per access keeps read data from a flop
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= !(wait_reg && (avs_read_i || avs_write_i));
            rdata_reg <= rd_mux;
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            desc_reg <= `DMD_RST_DESC;
            kind_reg <= `DMD_RST_KIND;
            query_reg <= 5'h00;
        end else begin
            if (wr_desc) begin
                desc_reg <= be_merge(desc_reg, avs_writedata_i, avs_byteenable_i);
            end
            if (wr_kind) begin
                kind_reg <= {2'b00, avs_writedata_i[5:4], 1'b0, avs_writedata_i[2:0]};
            end
            if (wr_query) begin
                query_reg <= avs_writedata_i[4:0];
            end
        end
    end

    // ----------------------------------------
    // Decode results
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            res0_reg <= 32'h0000_0000;
            res1_reg <= 32'h0000_0000;
            scratch_reg <= 17'h00000;
            invalid_reg <= 1'b0;
        end else begin
            res0_reg <= res0_next;
            res1_reg <= res1_next;
            scratch_reg <= scratch_next;
            invalid_reg <= !fields_ok;
        end
    end

    // ----------------------------------------
    // Access issue
    // ----------------------------------------
    // Decision uses live fields so a go right after a descriptor write sees it
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            issue_reg <= 1'b0;
            refuse_pulse_reg <= 1'b0;
            refused_reg <= 1'b0;
            adesc_reg <= 32'h0000_0000;
            akind_reg <= 3'h0;
        end else begin
            issue_reg <= go_cmd && fields_ok;
            refuse_pulse_reg <= go_cmd && !fields_ok;
            if (go_cmd && !fields_ok) begin
                refused_reg <= 1'b1;
            end else if (wr_status && avs_writedata_i[1]) begin
                refused_reg <= 1'b0;
            end
            if (go_cmd && fields_ok) begin
                adesc_reg <= desc_reg;
                akind_reg <= kind_reg[2:0];
            end
        end
    end

    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign access_issue_o = issue_reg;
    assign access_desc_o = adesc_reg;
    assign access_kind_o = akind_reg;
    assign access_refused_o = refuse_pulse_reg;
endmodule
`default_nettype wire

// *** bench/dmd_decoder_asserts.sv ***
// Port-level assertions for the descriptor decoder
`timescale 1ns/10ps
`default_nettype none
module dmd_decoder_asserts (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_waitrequest_o,
    // Access request
    input wire logic access_issue_o,
    input wire logic [31:0] access_desc_o,
    input wire logic [2:0] access_kind_o,
    input wire logic access_refused_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // ----
    // Shadow of the descriptor that GO fires
    // ----
    logic [31:0] desc_reg;
    logic [5:0] kind_reg;
    wire acc = avs_write_i && !avs_waitrequest_o;
    wire go = acc && avs_address_i == 5'h08 && avs_byteenable_i[0] && avs_writedata_i[0];
    wire [2:0] kd = kind_reg[2:0];
    wire [1:0] md = kind_reg[5:4];
    wire [3:0] cm = desc_reg[11:8];
    wire [2:0] bc = desc_reg[10:8];
    wire [1:0] hf = desc_reg[13:12];
    wire [7:0] ix = desc_reg[7:0];
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            desc_reg <= 32'h0;
            kind_reg <= 6'h0;
        end else if (acc && avs_address_i == 5'h04 && avs_byteenable_i[0]) begin
            kind_reg <= avs_writedata_i[5:0];
        end else if (acc && avs_address_i == 5'h00) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable_i[b]) begin
                    desc_reg[8*b +: 8] <= avs_writedata_i[8*b +: 8];
                end
            end
        end
    end
    // ----
    // Assertions
    // ----
    a_pulse_cause: assert property (access_issue_o || access_refused_o |-> $past(go))
        else $error("pulse without GO");
    a_go_answer: assert property (go |=> access_issue_o != access_refused_o)
        else $error("GO not answered once");
    a_issue_content: assert property (access_issue_o |-> access_desc_o == $past(desc_reg)
        && access_kind_o == $past(kd))
        else $error("issued fields differ");
    a_desc_hold: assert property (!access_issue_o |-> $stable(access_desc_o))
        else $error("descriptor moved");
    a_long_index: assert property (go && md == 2'h0 && kd != 3'h7 && ix != 8'hFF && ix != 8'hFD
        |=> access_refused_o)
        else $error("long index not refused");
    a_table_gap: assert property (go && md == 2'h2 && kd != 3'h7 && ix > 8'hEF && ix < 8'hFC
        |=> access_refused_o)
        else $error("index gap not refused");
    a_mask_empty: assert property (go && kd < 3'h4 && cm == 4'hF |=> access_refused_o)
        else $error("empty mask not refused");
    a_uw_mask: assert property (go && kd == 3'h1 && cm != 4'h0 && cm != 4'h8 && cm != 4'hC
        && cm != 4'hE |=> access_refused_o)
        else $error("write mask not refused");
    a_hex_long: assert property (go && kd == 3'h5 && md == 2'h0 && bc != 3'h1 && bc != 3'h2
        |=> access_refused_o)
        else $error("hex count not refused");
    a_oct_count: assert property (go && kd == 3'h6 && bc > 3'h4 |=> access_refused_o)
        else $error("oct count not refused");
    a_slot_range: assert property (go && (kd == 3'h2 || kd == 3'h3) && hf == 2'h3
        |=> access_refused_o)
        else $error("slot not refused");
    a_lane_code: assert property (go && kd < 3'h2 && (hf == 2'h0 || hf == 2'h3)
        |=> access_refused_o)
        else $error("lane width not refused");
    c_issue: cover property (go ##1 access_issue_o);
    c_refuse: cover property (go ##1 access_refused_o);
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind dmd_decoder dmd_decoder_asserts u_chk (
    .sys_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_waitrequest_o, .access_issue_o, .access_desc_o,
    .access_kind_o, .access_refused_o
);
`default_nettype wire

// *** bench/dmd_issuer.sv ***
// Execution-unit model: issues register accesses and forms descriptor fields
`timescale 1ns/10ps
`default_nettype none
module dmd_issuer (
    // Clock
    input wire logic clk_i,
    // Avalon-MM master
    output logic [4:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] writedata_o,
    output logic [3:0] byteenable_o,
    input wire logic waitrequest_i,
    input wire logic [31:0] readdata_i,
    // Wait ran out
    output logic hang_o
);
    initial begin
        address_o = 5'h1F;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h0;
        byteenable_o = 4'hF;
        hang_o = 1'b0;
    end
    // Request held until waitrequest is seen low; released bus shows inverted data
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        address_o <= a;
        writedata_o <= d;
        byteenable_o <= be;
        read_o <= !wr;
        write_o <= wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_i !== 1'b0 && n < 50);
        q = readdata_i;
        hang_o <= (n >= 50);
        read_o <= 1'b0;
        write_o <= 1'b0;
        address_o <= ~a;
        writedata_o <= ~d;
    endtask
    // Narrow instructions still send an eight-lane message
    function automatic logic [1:0] lane_code(input int exec);
        return (exec > 8) ? 2'h1 : 2'h2;
    endfunction
    // One register beyond the address registers is the header
    function automatic logic hdr_bit(input int regs, input int addr_regs);
        return regs == addr_regs + 1;
    endfunction
endmodule
`default_nettype wire

// *** bench/test_dmd_decoder.sv ***
// Self-checking bench for the descriptor decoder
`timescale 1ns/10ps
`default_nettype none
`define CMP(g, e) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("[FAIL] t=%0t got %h exp %h", $time, g, e); \
    end \
end
module test_dmd_decoder;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    wire [4:0] av_adr;
    wire av_rd, av_wr, av_wait, issue, refused, hang;
    wire [31:0] av_wd, av_rdata, adesc;
    wire [3:0] av_be;
    wire [2:0] akind;
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] q;
    logic [7:0] idx [7] = '{8'h05, 8'hEF, 8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'hF0};
    logic [2:0] cls [6] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h5, 3'h4};
    logic [3:0] uw [7] = '{4'h0, 4'h8, 4'hC, 4'hE, 4'h1, 4'h7, 4'h9};
    always #25 sys_clk_i = ~sys_clk_i;
    dmd_decoder DUT (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_address_i(av_adr), .avs_read_i(av_rd),
        .avs_write_i(av_wr), .avs_writedata_i(av_wd), .avs_byteenable_i(av_be),
        .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait), .access_issue_o(issue),
        .access_desc_o(adesc), .access_kind_o(akind), .access_refused_o(refused)
    );
    dmd_issuer u_eu (
        .clk_i(sys_clk_i), .address_o(av_adr), .read_o(av_rd), .write_o(av_wr),
        .writedata_o(av_wd), .byteenable_o(av_be), .waitrequest_i(av_wait),
        .readdata_i(av_rdata), .hang_o(hang)
    );
    // ----
    // Access tasks
    // ----
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        u_eu.xfer(1'b1, a, d, 4'hF, q);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        u_eu.xfer(1'b0, a, 32'h0, 4'hF, q);
        `CMP(q & m, e)
    endtask
    // Fires GO on a descriptor and kind; expects an issue or a refusal
    task automatic fire(input logic [31:0] d, input logic [5:0] k, input logic ok);
        wr(5'h00, d);
        wr(5'h04, {26'h0, k});
        wr(5'h08, 32'h1);
        @(negedge sys_clk_i);
        `CMP(issue, ok)
        `CMP(refused, !ok)
        if (ok) begin
            `CMP(adesc, d)
            `CMP(akind, k[2:0])
        end
        rdc(5'h0C, 32'h1, {31'h0, !ok});
    endtask
    task automatic conclude();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge hang) begin
        miscompares++;
        conclude();
    end
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rdc(5'h00, ~32'h0, 32'h0);
        wr(5'h00, 32'h1234_5678);
        u_eu.xfer(1'b1, 5'h00, 32'hAABB_CCDD, 4'h2, q);
        u_eu.xfer(1'b1, 5'h01, ~32'h0, 4'hF, q);
        rdc(5'h00, ~32'h0, 32'h1234_CC78);
        rdc(5'h02, ~32'h0, 32'h0);
        rdc(5'h08, ~32'h0, 32'h0);
        for (int i = 0; i < 7; i++) begin
            fire({24'h20, idx[i]}, 6'h20, i < 6);
            if (i < 6) rdc(5'h10, 32'hFF07, {16'h0, idx[i], 5'h0, cls[i]});
        end
        fire(32'h20FD, 6'h10, 1'b0);
        fire(32'h20FF, 6'h00, 1'b1);
        rdc(5'h10, 32'h7, 32'h4);
        fire(32'h20FD, 6'h00, 1'b1);
        rdc(5'h10, 32'h7, 32'h3);
        fire(32'h2005, 6'h00, 1'b0);
        for (int m = 0; m < 16; m++) begin
            fire({20'h2, 4'(m), 8'h05}, 6'h20, m != 15);
            if (m != 15) rdc(5'h10, 32'h7F_0000, {9'h0, 3'($countones(~4'(m))), ~4'(m), 16'h0});
        end
        for (int i = 0; i < 7; i++) fire({20'h2, uw[i], 8'h05}, 6'h21, i < 4);
        for (int e = 0; e < 4; e++) begin
            for (int l = 0; l < 2; l++) begin
                fire({20'h2, 2'(e), 1'b0, 1'(l), 8'h05}, 6'h24, 1'b1);
                rdc(5'h10, 32'h0F00_0000, (1 << e) << 24);
                rdc(5'h14, 32'h7F_FC00, {9'h0, 7'((1 << e) * (l + 1)), 1'(l), 5'(l ? 16 : 8), 10'h0});
                wr(5'h1C, 32'((1 << e) - 1));
                rdc(5'h1C, 32'h7F00, (((1 << e) - 1) * (l + 1)) << 8);
            end
        end
        fire({18'h0, u_eu.lane_code(16), 4'h0, 8'h05}, 6'h20, 1'b1);
        rdc(5'h14, 32'h7F_FC00, {9'h0, 7'h8, 1'b1, 5'h10, 10'h0});
        wr(5'h1C, {27'h0, 2'h3, 3'h0});
        rdc(5'h1C, 32'h7F1F, {17'h0, 7'h6, 3'h0, 5'h18});
        fire({18'h0, u_eu.lane_code(4), 4'h0, 8'h05}, 6'h20, 1'b1);
        rdc(5'h14, 32'h7F_FC00, {9'h0, 7'h4, 1'b0, 5'h08, 10'h0});
        fire(32'h0005, 6'h20, 1'b0);
        fire(32'h3005, 6'h20, 1'b0);
        fire({2'h3, 10'h0, u_eu.hdr_bit(5, 4), 19'h02005}, 6'h20, 1'b1);
        rdc(5'h10, 32'h3000_0000, 32'h3000_0000);
        fire({2'h0, 10'h0, u_eu.hdr_bit(4, 4), 19'h02005}, 6'h20, 1'b1);
        rdc(5'h10, 32'h3000_0000, 32'h0);
        for (int c = 0; c < 4; c++) begin
            fire({21'h0, 3'(c), 8'hFF}, 6'h05, c == 1 || c == 2);
            if (c == 1 || c == 2) rdc(5'h14, 32'hF, c);
        end
        for (int c = 0; c < 5; c++) begin
            fire({21'h0, 3'(c), 8'h05}, 6'h25, c < 4);
            if (c < 4) rdc(5'h14, 32'hF, 1 << c);
        end
        for (int c = 0; c < 6; c++) begin
            fire({21'h0, 3'(c), 8'h05}, 6'h26, c < 5);
            if (c < 5) rdc(5'h14, c < 2 ? 32'h8F : 32'hFF,
                {24'h0, c == 1, 3'(c < 2 ? 0 : 1 << (c - 2)), 4'(c < 2 ? 1 : 1 << (c - 1))});
        end
        for (int c = 0; c < 4; c++) begin
            fire({18'h0, 2'(c), 4'h0, 8'h05}, 6'h12, c < 3);
            if (c < 3) rdc(5'h14, 32'h300, c << 8);
        end
        fire(32'h0000_0FFF, 6'h27, 1'b1);
        rdc(5'h18, ~32'h0, 32'h0001_FFE0);
        fire(32'h0000_0001, 6'h27, 1'b1);
        rdc(5'h18, ~32'h0, 32'h0000_0020);
        fire(32'h2005, 6'h30, 1'b0);
        rdc(5'h0C, 32'h2, 32'h2);
        wr(5'h0C, 32'h2);
        rdc(5'h0C, 32'h2, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
